// *** mbw_pkg.sv ***
`default_nettype none
package mbw_pkg;
  // request layout, byte positions in the frame
  localparam int POS_TID_H = 0;
  localparam int POS_TID_L = 1;
  localparam int POS_PID_H = 2;
  localparam int POS_PID_L = 3;
  localparam int POS_LEN_H = 4;
  localparam int POS_LEN_L = 5;
  localparam int POS_UID = 6;
  localparam int POS_FC = 7;
  localparam int POS_ADDR_H = 8;
  localparam int POS_ADDR_L = 9;
  localparam int POS_QTY_H = 10;
  localparam int POS_QTY_L = 11;
  localparam int POS_BCNT = 12;
  localparam int POS_DATA = 13;
  localparam logic [8:0] IDX_MAX = 9'h1ff;
  localparam logic [8:0] IDX_BCNT = 9'h00c;
  localparam logic [8:0] IDX_DATA = 9'h00d;

  localparam logic [7:0] FC_WRITE_BITS = 8'h0f;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] ERR_NONE = 8'h00;

  // length field: unit id, fc, addr, qty, count byte, then data
  localparam logic [15:0] REQ_LEN_BASE = 16'h0007;
  localparam logic [15:0] QTY_MAX = 16'h07b0;
  localparam logic [7:0] RESP_LEN_OK = 8'h06;
  localparam logic [7:0] RESP_LEN_EXC = 8'h03;
  localparam logic [3:0] RESP_BYTES_OK = 4'hc;
  localparam logic [3:0] RESP_BYTES_EXC = 4'h9;

  // address map, bit spaces
  localparam logic [15:0] IN_BIT_LO = 16'h6000;
  localparam logic [15:0] IN_BIT_HI = 16'h63ff;
  localparam logic [15:0] OUT_BIT_LO = 16'ha000;
  localparam logic [15:0] OUT_BIT_HI = 16'ha3ff;
  // address map, word spaces
  localparam logic [15:0] IN_WORD_LO = 16'h8000;
  localparam logic [15:0] IN_WORD_HI = 16'h803f;
  localparam logic [15:0] OUT_WORD_LO = 16'ha000;
  localparam logic [15:0] OUT_WORD_HI = 16'ha03f;
  localparam logic [15:0] MEM_WORD_LO = 16'h0000;
  localparam logic [15:0] MEM_WORD_HI = 16'h7fff;

  localparam int OUT_BIT_COUNT = 1024;
  localparam int TX_FIFO_DEPTH = 8;
  localparam int TX_WIDTH = 9;

  typedef enum logic {st_rx, st_tx} mbw_state_t;
  typedef enum logic [1:0] {sp_none, sp_in_bit, sp_out_bit} mbw_space_t;
endpackage : mbw_pkg
`default_nettype wire

// *** mbw_stream_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mbw_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : mbw_stream_if
`default_nettype wire

// *** mbw_tx_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbw_tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  mbw_stream_if.snk push,
  mbw_stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] cnt;
  logic out_valid;
  logic [WIDTH-1:0] out_data;

  wire push_fire = push.valid && push.ready;
  wire load = (cnt != '0) && (!out_valid || pop.ready);

  // ready from the count so a stalled drain pushes back on the source
  assign push.ready = cnt != FULL_CNT;
  assign pop.valid = out_valid;
  assign pop.data = out_data;

  always_ff @(posedge ref_clk) begin
    if (push_fire) begin
      mem[wr_ptr] <= push.data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end else begin
      wr_ptr <= push_fire ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= load ? rd_ptr + 1'b1 : rd_ptr;
      cnt <= cnt + (AW+1)'(push_fire) - (AW+1)'(load);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (pop.ready) begin
      out_valid <= 1'b0;
    end
  end

  chk_fifo_bound: assert property (@(posedge ref_clk) disable iff (sys_rst) cnt <= FULL_CNT)
    else $error("fifo count above depth");
  chk_fifo_hold_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
    out_valid && !pop.ready |=> out_valid && $stable(out_data))
    else $error("fifo output changed while stalled");
  cov_fifo_full: cover property (@(posedge ref_clk) disable iff (sys_rst) cnt == FULL_CNT);
endmodule : mbw_tx_fifo
`default_nettype wire

// *** mbw_coil_write.sv ***
// What this block does
// - request header: transaction, protocol, length, unit id, function 0F
// - bytes 8 and 9 carry start bit address, high byte first
// - bytes 10 and 11 carry bit quantity, high byte first
// - byte 12 carries count of packed data bytes that follow
// - from byte 13, each byte writes up to eight consecutive bits from start, none past the bit quantity
// - success reply echoes header, length 6, unit, function, address, quantity
// - reject reply: function plus 80 hex, exception code at byte 8
// - input bits 6000-63FF read only, output bits A000-A3FF writable
// - input words 8000-803F, output words A000-A03F, memory 0000-7FFF
`timescale 1ns/1ps
`default_nettype none
module mbw_coil_write #(
  parameter int OUT_BITS = mbw_pkg::OUT_BIT_COUNT,
  parameter int FIFO_DEPTH = mbw_pkg::TX_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic [mbw_pkg::OUT_BIT_COUNT-1:0] output_bit_reg
);
  import mbw_pkg::*;

  if (OUT_BITS != OUT_BIT_COUNT) begin : g_bad
    $error("output bit space is fixed by the address map");
  end

  function automatic mbw_space_t bit_space(input logic [15:0] a);
    if (a >= OUT_BIT_LO && a <= OUT_BIT_HI) return sp_out_bit;
    if (a >= IN_BIT_LO && a <= IN_BIT_HI) return sp_in_bit;
    return sp_none;
  endfunction : bit_space

  mbw_state_t state;
  logic [8:0] idx;
  logic [15:0] tid, pid, len, addr, qty;
  logic [7:0] uid, fc, bcnt, err;
  logic [3:0] tx_idx;
  logic [3:0] resp_n;
  logic [OUT_BIT_COUNT-1:0] next_output_bit_reg;

  mbw_stream_if #(.W(TX_WIDTH)) push_if ();
  mbw_stream_if #(.W(TX_WIDTH)) pop_if ();

  mbw_tx_fifo #(.WIDTH(TX_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .push(push_if),
    .pop(pop_if)
  );

  assign tx_valid = pop_if.valid;
  assign tx_data = pop_if.data[7:0];
  assign tx_last = pop_if.data[8];
  assign pop_if.ready = tx_ready;

  wire take = rx_valid && rx_ready;
  wire at_bcnt = idx == IDX_BCNT;
  wire [15:0] qty_bytes = (qty + 16'h0007) >> 3;
  wire [15:0] last_addr = addr + qty - 16'h0001;
  wire [15:0] rx_word = {8'h00, rx_data};

  // checks made as the count byte arrives, before any data touches the bits
  wire fc_bad = fc != FC_WRITE_BITS;
  wire val_bad = qty == 16'h0000 || qty > QTY_MAX || rx_word != qty_bytes
    || len != REQ_LEN_BASE + rx_word;
  wire rng_bad = bit_space(addr) != sp_out_bit || bit_space(last_addr) != sp_out_bit;
  wire [7:0] hdr_err = fc_bad ? EXC_ILLEGAL_FUNC : val_bad ? EXC_ILLEGAL_VALUE
    : rng_bad ? EXC_ILLEGAL_ADDR : ERR_NONE;
  // a frame's first byte drops the code left by the frame before
  wire [7:0] cur_err = at_bcnt ? hdr_err : idx == 9'h000 ? ERR_NONE : err;
  wire [7:0] cur_bcnt = at_bcnt ? rx_data : bcnt;
  wire frame_len_bad = idx != IDX_BCNT + {1'b0, cur_bcnt};
  wire [7:0] end_err = cur_err != ERR_NONE ? cur_err : frame_len_bad ? EXC_ILLEGAL_VALUE : ERR_NONE;

  // data bytes land only once the header has proven clean
  wire data_wr = take && state == st_rx && idx >= IDX_DATA
    && idx < IDX_DATA + {1'b0, bcnt} && err == ERR_NONE;
  wire [8:0] byte_off = idx - IDX_DATA;
  wire [15:0] bit_first = {4'h0, byte_off, 3'b000};
  wire [9:0] bit_base = addr[9:0] - OUT_BIT_LO[9:0];
  wire [9:0] pos_first = bit_base + bit_first[9:0];

  logic [9:0] pos [8];
  logic [7:0] bit_en;
  for (genvar k = 0; k < 8; k++) begin : g_bit
    assign pos[k] = pos_first + 10'(k);
    assign bit_en[k] = data_wr && (bit_first + 16'(k) < qty);
  end

  always_comb begin
    next_output_bit_reg = output_bit_reg;
    for (int k = 0; k < 8; k++) begin
      if (bit_en[k]) begin
        next_output_bit_reg[pos[k]] = rx_data[k];
      end
    end
  end

  function automatic logic [7:0] resp_byte(input logic [3:0] i, input logic [7:0] e);
    case (i)
      4'h0: return tid[15:8];
      4'h1: return tid[7:0];
      4'h2: return pid[15:8];
      4'h3: return pid[7:0];
      4'h4: return 8'h00;
      4'h5: return e != ERR_NONE ? RESP_LEN_EXC : RESP_LEN_OK;
      4'h6: return uid;
      4'h7: return e != ERR_NONE ? (fc | EXC_FLAG) : fc;
      4'h8: return e != ERR_NONE ? e : addr[15:8];
      4'h9: return addr[7:0];
      4'ha: return qty[15:8];
      default: return qty[7:0];
    endcase
  endfunction : resp_byte

  wire push_fire = push_if.valid && push_if.ready;
  wire resp_end = tx_idx == resp_n - 4'h1;
  assign push_if.valid = state == st_tx;
  logic [7:0] resp_data;
  // not an assign: the function reads the stored header, which an assign would not watch
  always_comb begin
    resp_data = resp_byte(tx_idx, err);
  end
  assign push_if.data = {resp_end, resp_data};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tid <= '0;
      pid <= '0;
      len <= '0;
      uid <= '0;
      fc <= '0;
      addr <= '0;
      qty <= '0;
      bcnt <= '0;
    end else if (take) begin
      case (idx)
        9'(POS_TID_H): tid[15:8] <= rx_data;
        9'(POS_TID_L): tid[7:0] <= rx_data;
        9'(POS_PID_H): pid[15:8] <= rx_data;
        9'(POS_PID_L): pid[7:0] <= rx_data;
        9'(POS_LEN_H): len[15:8] <= rx_data;
        9'(POS_LEN_L): len[7:0] <= rx_data;
        9'(POS_UID): uid <= rx_data;
        9'(POS_FC): fc <= rx_data;
        9'(POS_ADDR_H): addr[15:8] <= rx_data;
        9'(POS_ADDR_L): addr[7:0] <= rx_data;
        9'(POS_QTY_H): qty[15:8] <= rx_data;
        9'(POS_QTY_L): qty[7:0] <= rx_data;
        9'(POS_BCNT): bcnt <= rx_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_bit_reg <= '0;
    end else begin
      output_bit_reg <= next_output_bit_reg;
    end
  end

  // the reply starts the cycle after the last data byte, so reads see new bits
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= st_rx;
      rx_ready <= 1'b1;
      idx <= '0;
      err <= ERR_NONE;
      tx_idx <= '0;
      resp_n <= RESP_BYTES_OK;
    end else begin
      unique case (state)
        st_rx: begin
          if (take && rx_last) begin
            state <= st_tx;
            rx_ready <= 1'b0;
            idx <= '0;
            err <= end_err;
            tx_idx <= '0;
            resp_n <= end_err != ERR_NONE ? RESP_BYTES_EXC : RESP_BYTES_OK;
          end else if (take) begin
            idx <= idx == IDX_MAX ? idx : idx + 9'h001;
            err <= idx == 9'h000 ? ERR_NONE : cur_err;
          end
        end
        st_tx: begin
          if (push_fire) begin
            tx_idx <= tx_idx + 4'h1;
            if (resp_end) begin
              state <= st_rx;
              rx_ready <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_tx_blocks_rx: assert property (state == st_tx |-> !rx_ready)
    else $error("request taken while replying");
  chk_ok_reply_len: assert property (state == st_tx && err == ERR_NONE |-> resp_n == RESP_BYTES_OK)
    else $error("normal reply not twelve bytes");
  chk_len_byte: assert property (push_fire && tx_idx == 4'h5
    |-> push_if.data[7:0] == (err != ERR_NONE ? RESP_LEN_EXC : RESP_LEN_OK))
    else $error("reply length byte wrong");
  chk_exc_func_byte: assert property (push_fire && tx_idx == 4'h7 && err != ERR_NONE
    |-> push_if.data[7:0] == (fc | EXC_FLAG) && resp_n == RESP_BYTES_EXC)
    else $error("exception function byte wrong");
  chk_no_write_err: assert property (|bit_en |-> err == ERR_NONE && !fc_bad)
    else $error("bits written on a rejected request");
  chk_write_in_map: assert property (|bit_en |-> bit_space(addr) == sp_out_bit
    && bit_space(last_addr) == sp_out_bit)
    else $error("write outside output bit space");
  chk_bad_fc_code: assert property (take && at_bcnt && !rx_last && fc != FC_WRITE_BITS
    |=> err == EXC_ILLEGAL_FUNC)
    else $error("bad function not flagged");
  chk_bit_lands: assert property (bit_en[0] |=> output_bit_reg[$past(pos_first)] == $past(rx_data[0]))
    else $error("data bit not written");
  chk_reply_after_last: assert property (take && rx_last |=> state == st_tx ##0 push_if.valid)
    else $error("reply not started after frame end");

  cov_ok_reply: cover property (push_fire && resp_end && err == ERR_NONE);
  cov_exc_reply: cover property (push_fire && resp_end && err == EXC_ILLEGAL_ADDR);
  cov_fifo_stall: cover property (push_if.valid && !push_if.ready);
endmodule : mbw_coil_write
`default_nettype wire

// *** mbw_client.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbw_client (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic tx_ready
);
  logic [3:0] stall_cnt;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
    stall_cnt = 4'h0;
  end

  // slow mode takes one reply byte in sixteen, so the fifo fills
  always @(posedge ref_clk) begin
    stall_cnt <= stall_cnt + 4'h1;
    tx_ready <= !slow || (stall_cnt == 4'h0);
  end

  // one byte a beat, held until taken; rx_last only on the final byte
  task automatic send(input logic [7:0] f[$]);
    int i;
    for (i = 0; i < f.size(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= f[i];
      rx_last <= (i == f.size() - 1);
      do @(posedge ref_clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    // released line shows the inverse, never a stale byte
    rx_data <= ~f[f.size() - 1];
  endtask : send
endmodule : mbw_client
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mbw_pkg::*;
  logic ref_clk, sys_rst, slow, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic [OUT_BIT_COUNT-1:0] output_bit_reg, exp_bits;
  logic [8:0] exp_q[$];
  logic [31:0] seed;
  int num_errors, num_checks, n;
  logic [15:0] a, q;
  logic [15:0] len_adj;
  int pad;

  mbw_coil_write i_mbw_coil_write (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .output_bit_reg(output_bit_reg));
  mbw_client i_mbw_client (.ref_clk(ref_clk), .slow(slow), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [1023:0] seen, input logic [1023:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // builds a request, notes its reply, then waits for the reply to drain
  task automatic run(input logic [7:0] fc, input logic [15:0] addr, input logic [15:0] qty,
                     input logic [7:0] bcnt, input logic [7:0] code);
    logic [7:0] f[$];
    logic [7:0] r[$];
    logic [7:0] d;
    logic [15:0] tid, len;
    int i, k;
    tid = xs();
    len = REQ_LEN_BASE + {8'h00, bcnt} + len_adj;
    f = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], 8'h01, fc};
    f = {f, addr[15:8], addr[7:0], qty[15:8], qty[7:0], bcnt};
    for (i = 0; i < bcnt; i++) begin
      d = xs();
      f.push_back(d);
      for (k = 0; k < 8; k++) begin
        if ((code == ERR_NONE || pad != 0) && 8 * i + k < qty) begin
          exp_bits[int'(addr - OUT_BIT_LO) + 8 * i + k] = d[k];
        end
      end
    end
    for (i = 0; i < pad; i++) begin
      d = xs();
      f.push_back(d);
    end
    r = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00};
    if (code == ERR_NONE) begin
      r = {r, RESP_LEN_OK, 8'h01, fc, addr[15:8], addr[7:0], qty[15:8], qty[7:0]};
    end else begin
      r = {r, RESP_LEN_EXC, 8'h01, fc | EXC_FLAG, code};
    end
    for (i = 0; i < r.size(); i++) begin
      exp_q.push_back({i == r.size() - 1, r[i]});
    end
    i_mbw_client.send(f);
    @(posedge ref_clk);
    chk(rx_ready, 1'b0);
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) begin
      @(posedge ref_clk);
    end
    chk(exp_q.size(), 0);
  endtask : run

  // reply watcher; bits must already hold the write when the last byte leaves
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1, 0);
      end else begin
        chk({tx_last, tx_data}, exp_q.pop_front());
      end
      if (tx_last === 1'b1) begin
        chk(output_bit_reg, exp_bits);
      end
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #(20000 * 100);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    seed = 32'd31;
    num_errors = 0;
    num_checks = 0;
    exp_bits = '0;
    len_adj = '0;
    pad = 0;
    sys_rst = 1'b1;
    slow = 1'b0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk(output_bit_reg, exp_bits);
    run(FC_WRITE_BITS, OUT_BIT_LO, 16'h0008, 8'h01, ERR_NONE);
    run(FC_WRITE_BITS, 16'ha3f0, 16'h0010, 8'h02, ERR_NONE);
    run(FC_WRITE_BITS, 16'ha005, 16'h000a, 8'h02, ERR_NONE);
    run(8'h05, OUT_BIT_LO, 16'h0008, 8'h01, EXC_ILLEGAL_FUNC);
    run(FC_WRITE_BITS, IN_BIT_LO, 16'h0008, 8'h01, EXC_ILLEGAL_ADDR);
    run(FC_WRITE_BITS, OUT_BIT_HI, 16'h0002, 8'h01, EXC_ILLEGAL_ADDR);
    run(FC_WRITE_BITS, OUT_BIT_LO, 16'h0009, 8'h01, EXC_ILLEGAL_VALUE);
    run(FC_WRITE_BITS, OUT_BIT_LO, 16'h0000, 8'h00, EXC_ILLEGAL_VALUE);
    // header length one too long, then a stray byte past the data
    len_adj = 16'h0001;
    run(FC_WRITE_BITS, OUT_BIT_LO, 16'h0008, 8'h01, EXC_ILLEGAL_VALUE);
    len_adj = 16'h0000;
    pad = 1;
    run(FC_WRITE_BITS, 16'ha010, 16'h0008, 8'h01, EXC_ILLEGAL_VALUE);
    pad = 0;
    // stalled sink, so the reply overruns the fifo and the block must wait
    slow <= 1'b1;
    run(FC_WRITE_BITS, 16'ha100, 16'h0040, 8'h08, ERR_NONE);
    run(FC_WRITE_BITS, OUT_BIT_LO, 16'h07b1, 8'hf7, EXC_ILLEGAL_VALUE);
    slow <= 1'b0;
    for (n = 0; n < 6; n++) begin
      a = OUT_BIT_LO + (xs() % 32'h300);
      q = 16'h0001 + (xs() % 32'h40);
      run(FC_WRITE_BITS, a, q, 8'((q + 16'h0007) >> 3), ERR_NONE);
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
